//--- logic/csc_pkg.sv
// Shared constants, types and helpers of the cam switching core
package csc_pkg;

  // ******************************************************
  // Widths and limits
  // ******************************************************
  localparam int POS_W = 16;
  localparam int DT_W = 6;
  localparam int MS_W = 15;
  localparam int IRQ_W = 3;
  localparam int STEPS_360 = 360;
  localparam int STEPS_1000 = 1000;
  localparam logic [MS_W-1:0] OFF_MS_MIN = 15'h0001;
  localparam logic [MS_W-1:0] OFF_MS_MAX = 15'h7ef4;
  localparam logic signed [17:0] DEV_LIMIT = 18'sh00003;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int TIME_BASE_MS = 1;
  localparam int MS_TICK_CYCLES = CLK_FREQ_HZ / 1000 * TIME_BASE_MS;

  // ******************************************************
  // Register map (byte addresses)
  // ******************************************************
  localparam int ADDR_W = 10;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_IRQ_STAT = 8'h08;
  localparam logic [7:0] A_IRQ_CLR = 8'h0c;
  localparam logic [7:0] A_IRQ_EN = 8'h10;
  localparam logic [7:0] A_POS = 8'h14;
  localparam logic [7:0] A_LOCK = 8'h18;
  localparam logic [7:0] A_OUTS = 8'h1c;
  localparam logic [7:0] A_DT_BLK0 = 8'h20;
  localparam logic [7:0] A_DT_BLK1 = 8'h24;
  localparam logic [7:0] A_LINK_OP = 8'h28;
  localparam logic [7:0] A_LINK_SEL = 8'h2c;
  localparam logic [7:0] A_MARKER = 8'h30;
  localparam logic [7:0] A_SHIFT = 8'h34;
  localparam logic [1:0] CAM_PAGE = 2'h1;
  localparam int CTRL_EN = 0;
  localparam int CTRL_DT_PER_OUT = 1;
  localparam int CTRL_SEP = 2;
  localparam int CTRL_ENC_LSB = 3;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int IRQ_DEV = 0;
  localparam int IRQ_CODE = 1;
  localparam int IRQ_LOCK = 2;

  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [1:0] {CSC_ENC_BIN = 2'h0, CSC_ENC_G360 = 2'h1,
                            CSC_ENC_G1000 = 2'h2} csc_enc_type_t;
  typedef enum logic [1:0] {CSC_DIR_BOTH = 2'h0, CSC_DIR_CW = 2'h1,
                            CSC_DIR_CCW = 2'h2} csc_dir_t;
  typedef enum {CSC_BUS_IDLE, CSC_BUS_FETCH, CSC_BUS_DONE} csc_bus_st_t;

  typedef struct packed {
    logic [1:0] spare;
    logic [MS_W-1:0] off_ms;
    logic timed;
    logic [1:0] dir;
    logic [DT_W-1:0] dt_off;
    logic [DT_W-1:0] dt_on;
    logic [POS_W-1:0] off_pos;
    logic [POS_W-1:0] on_pos;
  } csc_cam_t;

  typedef struct packed {
    logic [POS_W-1:0] pos;
    logic signed [2:0] speed;
    logic dir_cw;
    logic valid;
  } csc_enc_t;

  // Positions per revolution for the selected encoder type
  function automatic logic [16:0] csc_modulus(input logic [1:0] t);
    unique case (t)
      CSC_ENC_G360: csc_modulus = 17'(STEPS_360);
      CSC_ENC_G1000: csc_modulus = 17'(STEPS_1000);
      default: csc_modulus = 17'h10000;
    endcase
  endfunction

  // Folds a value lying within one revolution of the range back into it
  function automatic logic [16:0] csc_wrap(input logic signed [19:0] v,
                                           input logic [16:0] m);
    if (v < 0) begin
      csc_wrap = 17'(v + $signed({3'h0, m}));
    end else if (v >= $signed({3'h0, m})) begin
      csc_wrap = 17'(v - $signed({3'h0, m}));
    end else begin
      csc_wrap = 17'(v);
    end
  endfunction

endpackage

//--- logic/csc_cam_mem.sv
// Dual-port cam table memory with registered reads
`timescale 1ns/1ps
module csc_cam_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic mclk_i,
  // Bus port
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [1:0] a_we_i,
  input wire logic [31:0] a_wdata_i,
  output logic [63:0] a_rdata_o,
  // Scan port
  input wire logic [AW-1:0] b_addr_i,
  output logic [63:0] b_rdata_o
);
  logic [63:0] mem [DEPTH];

  always_ff @(posedge mclk_i) begin
    for (int h = 0; h < 2; h++) begin
      if (a_we_i[h]) begin
        mem[a_addr_i][32*h +: 32] <= a_wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end
endmodule

//--- logic/csc_enc_mon.sv
// Encoder decode, plausibility monitor and speed/direction estimate
`timescale 1ns/1ps
module csc_enc_mon
  import csc_pkg::*;
#(
  parameter int EXCESS_360 = 0,
  parameter int EXCESS_1000 = 0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Encoder sample
  input wire logic sample_i,
  input wire logic [15:0] code_i,
  input wire logic [1:0] type_i,
  // Results
  output csc_pkg::csc_enc_t enc_o,
  output logic dev_err_o,
  output logic code_err_o
);
  import csc_pkg::*;

  generate
    if (EXCESS_360 < 0 || EXCESS_360 > 65536 - STEPS_360 ||
        EXCESS_1000 < 0 || EXCESS_1000 > 65536 - STEPS_1000) begin : g_bad_cfg
      $error("csc_enc_mon: excess offsets must keep the code window in 16 bits");
    end
  endgenerate

  logic [15:0] bin;
  logic [16:0] m;
  logic [16:0] exc;
  logic bad;
  logic [15:0] dec;
  logic signed [17:0] d;

  always_comb begin
    bin[15] = code_i[15];
    for (int i = 14; i >= 0; i--) begin
      bin[i] = bin[i+1] ^ code_i[i];
    end
    // Plain binary encoders bypass the Gray decode
    if (type_i == CSC_ENC_BIN) begin
      bin = code_i;
    end
    m = csc_modulus(type_i);
    unique case (type_i)
      CSC_ENC_G360: exc = 17'(EXCESS_360);
      CSC_ENC_G1000: exc = 17'(EXCESS_1000);
      default: exc = 17'h0;
    endcase
    // Gray codes outside the excess window are not valid positions
    bad = (type_i != CSC_ENC_BIN) && (({1'b0, bin} < exc) || ({1'b0, bin} >= exc + m));
    dec = 16'({1'b0, bin} - exc);
    d = $signed({2'h0, dec}) - $signed({2'h0, enc_o.pos});
    // Shortest way round the revolution
    if (d > $signed({1'b0, m[16:1]})) begin
      d = d - $signed({1'b0, m});
    end else if (d < -$signed({1'b0, m[16:1]})) begin
      d = d + $signed({1'b0, m});
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      enc_o <= '0;
      dev_err_o <= 1'b0;
      code_err_o <= 1'b0;
    end else begin
      dev_err_o <= 1'b0;
      code_err_o <= 1'b0;
      if (sample_i) begin
        if (bad) begin
          code_err_o <= 1'b1;
        end else begin
          enc_o.pos <= dec;
          enc_o.valid <= 1'b1;
          if (enc_o.valid) begin
            if (d >= DEV_LIMIT || d <= -DEV_LIMIT) begin
              dev_err_o <= 1'b1;
              enc_o.speed <= 3'sh0;
            end else begin
              enc_o.speed <= 3'(d);
            end
            if (d > 0) begin
              enc_o.dir_cw <= 1'b1;
            end else if (d < 0) begin
              enc_o.dir_cw <= 1'b0;
            end
          end
        end
      end
    end
  end
endmodule

//--- logic/csc_core.sv
// Cam switching core: cam table, dead-time compensation, monitor, link logic
//
// Summary of operation
// - Each cam point is moved ahead by measured speed times its dead time.
// - Dead times come per block of eight outputs or per single output.
// - With separate edges the on point and the off point use their own delays.
// - A timed cam switches on at its on point and off after its duration.
// - Timed durations are held within 1 ms to 32500 ms.
// - Each cam acts clockwise only, counter-clockwise only, or both (default).
// - A jump of three increments or more between samples raises an error.
// - An invalid excess-Gray code for 360 or 1000 steps raises an error.
// - Locked outputs refuse cam table writes; unlocked ones accept them.
// - Inputs, markers, a shift register and cams are linked per output.
`timescale 1ns/1ps
module csc_core
  import csc_pkg::*;
#(
  parameter int N_OUT = 16,
  parameter int MS_TICKS = MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [csc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Encoder
  input wire logic enc_valid_i,
  input wire logic [15:0] enc_code_i,
  // Plant inputs and shift register feed
  input wire logic [N_OUT-1:0] in_i,
  input wire logic shift_clk_i,
  input wire logic shift_data_i,
  // Outputs
  output logic [N_OUT-1:0] cam_out_o,
  output logic irq_o
);
  import csc_pkg::*;

  localparam int IW = 4;
  localparam int TW = $clog2(MS_TICKS + 1);

  generate
    if (N_OUT < 2 || N_OUT > 16 || MS_TICKS < 1) begin : g_bad_cfg
      $error("csc_core: N_OUT must be 2..16 and MS_TICKS positive");
    end
  endgenerate

  // ******************************************************
  // Address decode
  // ******************************************************
  function automatic logic is_cam(input logic [ADDR_W-1:0] a);
    is_cam = (a[9:8] == CAM_PAGE) && (a[7] == 1'b0) && (int'(a[6:3]) < N_OUT);
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    is_reg = (a[9:8] == 2'h0) && (a[7:0] == off);
  endfunction

  // ******************************************************
  // State
  // ******************************************************
  csc_bus_st_t bus_st;
  logic [4:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] ev;
  logic [N_OUT-1:0] lock;
  logic [N_OUT-1:0] marker;
  logic [N_OUT-1:0] cam_state;
  logic [N_OUT-1:0] prev_in;
  logic [N_OUT-1:0] next_out;
  logic [N_OUT-1:0] shreg;
  logic shift_prev;
  logic [2*DT_W-1:0] dt_blk [2];
  logic [2*N_OUT-1:0] link_op;
  logic [2*N_OUT-1:0] link_sel;
  logic [MS_W-1:0] timer [N_OUT];
  logic [TW-1:0] ms_cnt;
  logic ms_tick;
  logic [IW-1:0] scan_idx;
  logic [IW-1:0] eval_idx;
  logic req;
  logic wr_fire;
  logic cam_wr;
  logic [1:0] mem_we;
  logic [63:0] mem_a_q;
  logic [63:0] mem_b_q;
  csc_cam_t cam;
  csc_enc_t enc;
  logic dev_err;
  logic code_err;

  // ******************************************************
  // Bus slave: two wait states on every access
  // ******************************************************
  assign req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && (bus_st != CSC_BUS_DONE);
  assign wr_fire = avs_write_i && (bus_st == CSC_BUS_DONE);
  assign cam_wr = wr_fire && is_cam(avs_address_i);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bus_st <= CSC_BUS_IDLE;
    end else begin
      unique case (bus_st)
        CSC_BUS_IDLE: bus_st <= req ? CSC_BUS_FETCH : CSC_BUS_IDLE;
        CSC_BUS_FETCH: bus_st <= CSC_BUS_DONE;
        CSC_BUS_DONE: bus_st <= CSC_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0;
    end else if (bus_st == CSC_BUS_FETCH && avs_read_i) begin
      avs_readdata_o <= 32'h0;
      if (is_cam(avs_address_i)) begin
        avs_readdata_o <= avs_address_i[2] ? mem_a_q[63:32] : mem_a_q[31:0];
      end else if (avs_address_i[9:8] == 2'h0) begin
        unique case (avs_address_i[7:0])
          A_CTRL: avs_readdata_o <= 32'(ctrl);
          A_STATUS: avs_readdata_o <= 32'({enc.speed, enc.valid, enc.dir_cw});
          A_IRQ_STAT: avs_readdata_o <= 32'(irq_stat);
          A_IRQ_EN: avs_readdata_o <= 32'(irq_en);
          A_POS: avs_readdata_o <= 32'(enc.pos);
          A_LOCK: avs_readdata_o <= 32'(lock);
          A_OUTS: avs_readdata_o <= 32'(cam_out_o);
          A_DT_BLK0: avs_readdata_o <= 32'(dt_blk[0]);
          A_DT_BLK1: avs_readdata_o <= 32'(dt_blk[1]);
          A_LINK_OP: avs_readdata_o <= 32'(link_op);
          A_LINK_SEL: avs_readdata_o <= 32'(link_sel);
          A_MARKER: avs_readdata_o <= 32'(marker);
          A_SHIFT: avs_readdata_o <= 32'(shreg);
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  // ******************************************************
  // Configuration registers
  // ******************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RST;
      irq_en <= '0;
      lock <= '0;
      marker <= '0;
      dt_blk[0] <= '0;
      dt_blk[1] <= '0;
      link_op <= '0;
      link_sel <= '0;
    end else if (wr_fire) begin
      if (is_reg(avs_address_i, A_CTRL)) ctrl <= avs_writedata_i[4:0];
      if (is_reg(avs_address_i, A_IRQ_EN)) irq_en <= avs_writedata_i[IRQ_W-1:0];
      // Lock mask stays writable so setup can change what is protected
      if (is_reg(avs_address_i, A_LOCK)) lock <= avs_writedata_i[N_OUT-1:0];
      if (is_reg(avs_address_i, A_MARKER)) marker <= avs_writedata_i[N_OUT-1:0];
      if (is_reg(avs_address_i, A_DT_BLK0)) dt_blk[0] <= avs_writedata_i[2*DT_W-1:0];
      if (is_reg(avs_address_i, A_DT_BLK1)) dt_blk[1] <= avs_writedata_i[2*DT_W-1:0];
      if (is_reg(avs_address_i, A_LINK_OP)) link_op <= avs_writedata_i[2*N_OUT-1:0];
      if (is_reg(avs_address_i, A_LINK_SEL)) link_sel <= avs_writedata_i[2*N_OUT-1:0];
    end
  end

  // ******************************************************
  // Cam table
  // ******************************************************
  always_comb begin
    mem_we = 2'h0;
    if (cam_wr && !lock[avs_address_i[6:3]]) begin
      mem_we = avs_address_i[2] ? 2'h2 : 2'h1;
    end
  end

  csc_cam_mem #(
    .DEPTH(N_OUT),
    .AW(IW)
  ) u_mem (
    .mclk_i(mclk_i),
    .a_addr_i(avs_address_i[6:3]),
    .a_we_i(mem_we),
    .a_wdata_i(avs_writedata_i),
    .a_rdata_o(mem_a_q),
    .b_addr_i(scan_idx),
    .b_rdata_o(mem_b_q)
  );

  // ******************************************************
  // Encoder monitor and interrupts
  // ******************************************************
  csc_enc_mon u_enc (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .sample_i(enc_valid_i),
    .code_i(enc_code_i),
    .type_i(ctrl[CTRL_ENC_LSB +: 2]),
    .enc_o(enc),
    .dev_err_o(dev_err),
    .code_err_o(code_err)
  );

  always_comb begin
    ev = '0;
    ev[IRQ_DEV] = dev_err;
    ev[IRQ_CODE] = code_err;
    ev[IRQ_LOCK] = cam_wr && lock[avs_address_i[6:3]];
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_stat <= '0;
    end else if (wr_fire && is_reg(avs_address_i, A_IRQ_CLR)) begin
      irq_stat <= (irq_stat & ~avs_writedata_i[IRQ_W-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  assign irq_o = |(irq_stat & irq_en);

  // ******************************************************
  // Scan and evaluation
  // ******************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scan_idx <= '0;
      eval_idx <= '0;
    end else begin
      scan_idx <= (int'(scan_idx) == N_OUT - 1) ? '0 : scan_idx + 1'b1;
      eval_idx <= scan_idx;
    end
  end

  assign cam = csc_cam_t'(mem_b_q);

  logic [16:0] m;
  logic [DT_W-1:0] dt_on_sel;
  logic [DT_W-1:0] dt_off_sel;
  logic signed [19:0] adv_on;
  logic signed [19:0] adv_off;
  logic [16:0] on_eff;
  logic [16:0] off_eff;
  logic in_win;
  logic dir_ok;
  logic start;
  logic [MS_W-1:0] dur;

  always_comb begin
    m = csc_modulus(ctrl[CTRL_ENC_LSB +: 2]);
    if (ctrl[CTRL_DT_PER_OUT]) begin
      dt_on_sel = cam.dt_on;
      dt_off_sel = cam.dt_off;
    end else begin
      dt_on_sel = dt_blk[eval_idx[3]][DT_W-1:0];
      dt_off_sel = dt_blk[eval_idx[3]][2*DT_W-1:DT_W];
    end
    if (!ctrl[CTRL_SEP]) begin
      dt_off_sel = dt_on_sel;
    end
    // Signed speed moves the points against the direction of travel
    // Widened before the product so speed times a long delay cannot overflow
    adv_on = 20'(enc.speed) * 20'($signed({1'b0, dt_on_sel}));
    adv_off = 20'(enc.speed) * 20'($signed({1'b0, dt_off_sel}));
    on_eff = csc_wrap($signed({4'h0, cam.on_pos}) - adv_on, m);
    off_eff = csc_wrap($signed({4'h0, cam.off_pos}) - adv_off, m);
    in_win = csc_wrap($signed({4'h0, enc.pos}) - $signed({3'h0, on_eff}), m)
           < csc_wrap($signed({3'h0, off_eff}) - $signed({3'h0, on_eff}), m);
    unique case (cam.dir)
      CSC_DIR_BOTH: dir_ok = 1'b1;
      CSC_DIR_CW: dir_ok = enc.dir_cw;
      CSC_DIR_CCW: dir_ok = !enc.dir_cw;
      default: dir_ok = 1'b0;
    endcase
    start = cam.timed && in_win && !prev_in[eval_idx] && dir_ok;
    dur = cam.off_ms;
    if (dur < OFF_MS_MIN) dur = OFF_MS_MIN;
    if (dur > OFF_MS_MAX) dur = OFF_MS_MAX;
  end

  // ******************************************************
  // Millisecond base and timed cams
  // ******************************************************
  assign ms_tick = (int'(ms_cnt) == MS_TICKS - 1);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N_OUT; i++) timer[i] <= '0;
    end else begin
      for (int i = 0; i < N_OUT; i++) begin
        if (i == int'(eval_idx) && start) begin
          timer[i] <= dur;
        end else if (ms_tick && timer[i] != '0) begin
          timer[i] <= timer[i] - 1'b1;
        end
      end
    end
  end

  // Position no longer matters once a timed cam has started
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cam_state <= '0;
      prev_in <= '0;
    end else begin
      prev_in[eval_idx] <= in_win;
      if (!ctrl[CTRL_EN]) begin
        cam_state[eval_idx] <= 1'b0;
      end else if (cam.timed) begin
        cam_state[eval_idx] <= start || timer[eval_idx] != '0;
      end else begin
        cam_state[eval_idx] <= in_win && dir_ok;
      end
    end
  end

  // ******************************************************
  // Shift register and logic linking
  // ******************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      shreg <= '0;
      shift_prev <= 1'b0;
    end else begin
      shift_prev <= shift_clk_i;
      if (shift_clk_i && !shift_prev) begin
        shreg <= {shreg[N_OUT-2:0], shift_data_i};
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_link
      logic src;
      always_comb begin
        unique case (link_sel[2*g +: 2])
          2'h0: src = in_i[g];
          2'h1: src = marker[g];
          2'h2: src = shreg[g];
          default: src = cam_state[(g + 1) % N_OUT];
        endcase
        unique case (link_op[2*g +: 2])
          2'h0: next_out[g] = cam_state[g];
          2'h1: next_out[g] = cam_state[g] & src;
          2'h2: next_out[g] = cam_state[g] | src;
          default: next_out[g] = cam_state[g] ^ src;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cam_out_o <= '0;
    end else begin
      cam_out_o <= next_out;
    end
  end
endmodule

//--- test/csc_enc_model.sv
// Behavioural absolute encoder presenting one position per sample
`timescale 1ns/1ps
module csc_enc_model (
  // Clock
  input wire logic mclk_i,
  // Encoder lines
  output logic valid_o,
  output logic [15:0] code_o
);
  initial begin
    valid_o = 1'b0;
    code_o = 16'h0000;
  end

  // Code keeps standing after the strobe, like a real parallel encoder
  task automatic send(input logic [15:0] code, input int gap);
    @(posedge mclk_i);
    valid_o <= 1'b1;
    code_o <= code;
    @(posedge mclk_i);
    valid_o <= 1'b0;
    repeat (gap) @(posedge mclk_i);
  endtask
endmodule

//--- test/csc_core_sva.sv
// Port-level checks of the cam switching core
`timescale 1ns/1ps
module csc_core_sva
  import csc_pkg::*;
#(
  parameter int N_OUT = 16,
  parameter int MS_TICKS = MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Plant side
  input wire logic enc_valid_i,
  input wire logic [N_OUT-1:0] in_i,
  input wire logic shift_clk_i,
  input wire logic [N_OUT-1:0] cam_out_o,
  input wire logic irq_o
);
  logic req;
  logic acc_wr;
  logic [9:0] quiet;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  assign req = avs_read_i | avs_write_i;
  assign acc_wr = avs_write_i & ~avs_waitrequest_o;

  // Cycles since anything that may legally switch an output on
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || enc_valid_i || acc_wr || $changed(in_i) || $changed(shift_clk_i)) begin
      quiet <= 10'h000;
    end else if (quiet != 10'h3ff) begin
      quiet <= quiet + 10'h001;
    end
  end

  sequence s_two_waits;
    avs_waitrequest_o [*2] ##1 !avs_waitrequest_o;
  endsequence

  wait_two_a: assert property ($rose(req) |-> s_two_waits)
    else $error("waitrequest not low after exactly two cycles");
  wait_once_a: assert property (req && !avs_waitrequest_o |=> !req || avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  idle_no_wait_a: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest high without a request");
  read_stands_a: assert property (avs_read_i && !avs_waitrequest_o |=> $stable(avs_readdata_o))
    else $error("read data moved after the read ended");
  reset_quiet_a: assert property ($rose(rst_n_i) |-> cam_out_o == '0 && !irq_o)
    else $error("outputs not quiet after reset");
  irq_cause_a: assert property (
    $rose(irq_o) |-> $past(enc_valid_i, 2) || $past(acc_wr) || $past(acc_wr, 2))
    else $error("interrupt rose without a sample or a write");
  irq_drop_a: assert property ($fell(irq_o) |-> $past(acc_wr))
    else $error("interrupt fell without a write");
  cam_cause_a: assert property (
    |(cam_out_o & ~$past(cam_out_o)) |-> quiet <= 10'(N_OUT + 3))
    else $error("cam output switched on without a recent cause");
endmodule

bind csc_core csc_core_sva #(.N_OUT(N_OUT), .MS_TICKS(MS_TICKS)) u_sva (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .enc_valid_i(enc_valid_i), .in_i(in_i),
  .shift_clk_i(shift_clk_i), .cam_out_o(cam_out_o), .irq_o(irq_o));

//--- test/cam_switching_core_tb.sv
// Self-checking bench for the cam switching core
`timescale 1ns/1ps
module cam_switching_core_tb;
  import csc_pkg::*;
  localparam int NO = 16;
  localparam int MT = 20;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat;
  logic wrq;
  logic ev;
  logic [15:0] ec;
  logic [NO-1:0] in_v = '0;
  logic sck = 1'b0;
  logic sdat = 1'b0;
  logic [NO-1:0] outs;
  logic irq;
  logic [31:0] v;
  int mismatches = 0;
  int n_checks = 0;

  always #2.5 mclk_i = ~mclk_i;

  csc_core #(.N_OUT(NO), .MS_TICKS(MT)) dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wrq), .enc_valid_i(ev), .enc_code_i(ec), .in_i(in_v),
    .shift_clk_i(sck), .shift_data_i(sdat), .cam_out_o(outs), .irq_o(irq));
  csc_enc_model enc (.mclk_i(mclk_i), .valid_o(ev), .code_o(ec));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Request stands until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wrq !== 1'b0 && n < 50);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wrq !== 1'b0) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic wrg(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, {2'h0, a}, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, {2'h0, a}, 32'h0);
    check(v, e);
  endtask

  task automatic cam(input int i, input logic [15:0] on, input logic [15:0] off,
                     input logic [31:0] hi);
    acc(1'b1, 10'(12'h100 + 8 * i), {off, on});
    acc(1'b1, 10'(12'h104 + 8 * i), hi);
  endtask

  task automatic wo(input int i, input logic e, input int b);
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (outs[i] !== e && n < b);
    check(32'(outs[i]), 32'(e));
    if (outs[i] !== e) close_out();
  endtask

  function automatic logic [15:0] gy(input logic [15:0] p);
    return p ^ (p >> 1);
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rdc(A_CTRL, 32'h0);
    rdc(A_IRQ_STAT, 32'h0);
    acc(1'b1, 10'h3fc, 32'hffff_ffff);
    acc(1'b0, 10'h3fc, 32'h0);
    check(v, 32'h0);
    for (int i = 0; i < NO; i++) begin
      cam(i, 16'h0, 16'h0, 32'h0);
    end
    cam(0, 16'h64, 16'hc8, 32'h0);
    cam(1, 16'ha0, 16'h12c, 32'h0);
    cam(2, 16'h64, 16'h9c, 32'hc0);
    cam(3, 16'h64, 16'hc8, 32'h2000);
    cam(4, 16'h64, 16'hc8, 32'h1000);
    cam(5, 16'h97, 16'h98, 32'h4000);
    cam(7, 16'h64, 16'hc8, 32'h0);
    cam(9, 16'h64, 16'hc8, 32'h0);
    wrg(A_IRQ_EN, 32'h1);
    enc.send(16'hfffe, 0);
    enc.send(16'hffff, 0);
    enc.send(16'h0000, 0);
    rdc(A_STATUS, 32'h7);
    enc.send(16'hffff, 0);
    rdc(A_STATUS, 32'h1e);
    rdc(A_IRQ_STAT, 32'h0);
    enc.send(16'h0002, 3);
    check(32'(irq), 32'h1);
    rdc(A_IRQ_STAT, 32'h1);
    wrg(A_IRQ_EN, 32'h0);
    @(negedge mclk_i);
    check(32'(irq), 32'h0);
    wrg(A_IRQ_CLR, 32'h1);
    rdc(A_IRQ_STAT, 32'h0);
    wrg(A_IRQ_EN, 32'h7);
    for (int t = 1; t <= 2; t++) begin
      wrg(A_CTRL, 32'(t << 3));
      enc.send(gy(t == 1 ? 16'h190 : 16'h3f2), 0);
      rdc(A_POS, 32'h2);
      acc(1'b0, {2'h0, A_IRQ_STAT}, 32'h0);
      check(v & 32'h2, 32'h2);
      wrg(A_IRQ_CLR, 32'h3);
    end
    wrg(A_DT_BLK0, 32'h104);
    wrg(A_CTRL, 32'h1);
    enc.send(16'h96, 0);
    wo(0, 1'b1, NO + 4);
    enc.send(16'h98, 0);
    wo(1, 1'b1, NO + 4);
    wrg(A_CTRL, 32'h3);
    wo(1, 1'b0, NO + 4);
    wo(2, 1'b1, NO + 4);
    wrg(A_CTRL, 32'h7);
    wo(2, 1'b0, NO + 4);
    wo(3, 1'b0, NO + 4);
    wo(4, 1'b1, NO + 4);
    enc.send(16'h97, 0);
    wo(5, 1'b1, NO + 4);
    wo(3, 1'b1, NO + 4);
    wo(4, 1'b0, NO + 4);
    wo(5, 1'b0, 3 * MT + NO);
    wrg(A_LINK_OP, 32'hc4000);
    wrg(A_LINK_SEL, 32'h80000);
    wo(7, 1'b0, NO + 4);
    @(posedge mclk_i);
    in_v[7] <= 1'b1;
    sdat <= 1'b1;
    wo(7, 1'b1, NO + 4);
    repeat (NO) begin
      @(posedge mclk_i);
      sck <= 1'b1;
      @(posedge mclk_i);
      sck <= 1'b0;
    end
    rdc(A_SHIFT, 32'hffff);
    wo(9, 1'b0, NO + 4);
    wrg(A_IRQ_CLR, 32'h7);
    wrg(A_LOCK, 32'h1);
    cam(0, 16'h12c, 16'h190, 32'h0);
    rdc(A_IRQ_STAT, 32'h4);
    repeat (NO + 4) @(posedge mclk_i);
    wo(0, 1'b1, 1);
    close_out();
  end
endmodule
